// >>> hdl/pll_lock_sdm_alc_control_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "pll_ctrl_defines.vh"

// Summary of operation
// - Lock count field picks 1024, 2048, 4096 or 8192 in-window cycles before lock.
// - With loss-of-lock enabled, losing the reference drops a high lock indication.
// - Bleed polarity bit 5: zero negative bleed, one positive bleed.
// - Readback select: zero returns VCO/band/bias data, one returns version ID.
// - Half-LSB is added to primary fraction only while auxiliary modulator is off.
// - Integer word write resets the modulator unless the reset mask is set.
// - Modulator control bit one disables the modulator, zero enables it.
// - Level control register bit 0 zero enables automatic VCO level control.
// - Level control register bit 1 one enables temperature calibration voltage.
// - Core D rectifier bias, low threshold and nominal threshold fields per supply.
module pll_lock_sdm_alc_control_regs (
	input wire ref_clk,
	input wire rst,
	input wire reg_wr,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire pfd_strobe,
	input wire pfd_in_window,
	input wire ref_present,
	input wire [7:0] vco_band_bias_data,
	output wire lock_detect,
	output reg [7:0] readback_data,
	output wire bleed_polarity,
	output wire spare_select,
	output wire half_lsb_effective,
	output wire aux_modulator_enable,
	output wire modulator_disable_integer,
	output reg sdm_reset,
	output wire level_control_enable,
	output wire temp_calibration_voltage_enable,
	output wire core_d_rectifier_bias_select,
	output wire core_d_low_threshold_select,
	output wire [2:0] core_d_nominal_threshold
);
	reg [7:0] lock_detect_config_reg;
	reg [7:0] bleed_polarity_readback_select_reg;
	reg [7:0] sigma_delta_control_reg;
	reg [7:0] vco_level_control_core_d_reg;
	reg [7:0] rdata_next;
	wire wr_lock;
	wire wr_bleed;
	wire wr_sd;
	wire wr_vco;
	wire wr_int_word;
	wire half_lsb_add;

	// Address decode for writes
	assign wr_lock = reg_wr && (reg_addr == `ADDR_LOCK_DETECT);
	assign wr_bleed = reg_wr && (reg_addr == `ADDR_BLEED_READBACK);
	assign wr_sd = reg_wr && (reg_addr == `ADDR_SIGMA_DELTA);
	assign wr_vco = reg_wr && (reg_addr == `ADDR_VCO_LEVEL_D);
	assign wr_int_word = reg_wr && (reg_addr == `ADDR_INTEGER_WORD);

	// Storage; masking on write keeps reserved bits at zero
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lock_detect_config_reg <= `RST_LOCK_DETECT;
			bleed_polarity_readback_select_reg <= `RST_BLEED_READBACK;
			sigma_delta_control_reg <= `RST_SIGMA_DELTA;
			vco_level_control_core_d_reg <= `RST_VCO_LEVEL_D;
		end else begin
			if (wr_lock)
				lock_detect_config_reg <= reg_wdata & `MASK_LOCK_DETECT;
			if (wr_bleed)
				bleed_polarity_readback_select_reg <= reg_wdata & `MASK_BLEED_READBACK;
			if (wr_sd)
				sigma_delta_control_reg <= reg_wdata & `MASK_SIGMA_DELTA;
			if (wr_vco)
				vco_level_control_core_d_reg <= reg_wdata & `MASK_VCO_LEVEL_D;
		end
	end

	// Read mux; unmapped addresses answer zero
	always @* begin
		case (reg_addr)
			`ADDR_LOCK_DETECT: rdata_next = lock_detect_config_reg;
			`ADDR_BLEED_READBACK: rdata_next = bleed_polarity_readback_select_reg;
			`ADDR_SIGMA_DELTA: rdata_next = sigma_delta_control_reg;
			`ADDR_VCO_LEVEL_D: rdata_next = vco_level_control_core_d_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	// Registered read data and readback source, one cycle behind the select
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
			readback_data <= 8'h00;
		end else begin
			reg_rdata <= rdata_next;
			if (bleed_polarity_readback_select_reg[`READ_SEL_BIT])
				readback_data <= `VERSION_ID;
			else
				readback_data <= vco_band_bias_data;
		end
	end

	// Modulator reset on an integer word write unless masked; the word itself lives elsewhere
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			sdm_reset <= 1'b0;
		else
			sdm_reset <= wr_int_word && !sigma_delta_control_reg[`RESET_MASK_BIT];
	end

	// Control fields steering the analog and modulator blocks
	assign bleed_polarity = bleed_polarity_readback_select_reg[`BLEED_POLARITY_BIT];
	assign spare_select = bleed_polarity_readback_select_reg[`SPARE_SEL_BIT];
	assign aux_modulator_enable = sigma_delta_control_reg[`AUX_MOD_BIT];
	assign half_lsb_add = sigma_delta_control_reg[`HALF_LSB_BIT];
	// Ignored while the auxiliary modulator runs, which supplies its own dither
	assign half_lsb_effective = half_lsb_add && !aux_modulator_enable;
	assign modulator_disable_integer = sigma_delta_control_reg[`MOD_DISABLE_BIT];
	assign level_control_enable = !vco_level_control_core_d_reg[`LEVEL_DISABLE_BIT];
	assign temp_calibration_voltage_enable = vco_level_control_core_d_reg[`TEMP_CAL_BIT];
	assign core_d_rectifier_bias_select = vco_level_control_core_d_reg[`RECT_BIAS_BIT];
	assign core_d_low_threshold_select = vco_level_control_core_d_reg[`LOW_THRESH_BIT];
	assign core_d_nominal_threshold =
		vco_level_control_core_d_reg[`NOM_THRESH_MSB:`NOM_THRESH_LSB];

	// Digital lock detector
	lock_detector u_lock_detector (
		.ref_clk(ref_clk),
		.rst(rst),
		.lock_count_select(lock_detect_config_reg[`LOCK_COUNT_MSB:`LOCK_COUNT_LSB]),
		.loss_of_lock_enable(lock_detect_config_reg[`LOSS_LOCK_BIT]),
		.pfd_strobe(pfd_strobe),
		.pfd_in_window(pfd_in_window),
		.ref_present(ref_present),
		.lock_detect(lock_detect)
	);
endmodule // pll_lock_sdm_alc_control_regs

`default_nettype wire

// >>> hdl/pll_ctrl_defines.vh
`ifndef PLL_CTRL_DEFINES_VH
`define PLL_CTRL_DEFINES_VH

// Register offsets on the internal register port
`define ADDR_INTEGER_WORD 8'h10
`define ADDR_LOCK_DETECT 8'h28
`define ADDR_BLEED_READBACK 8'h2a
`define ADDR_SIGMA_DELTA 8'h2b
`define ADDR_VCO_LEVEL_D 8'h2c

// Reset values
`define RST_LOCK_DETECT 8'h03
`define RST_BLEED_READBACK 8'h00
`define RST_SIGMA_DELTA 8'h01
`define RST_VCO_LEVEL_D 8'h44

// Writable bit masks; everything else is reserved and reads zero
`define MASK_LOCK_DETECT 8'h07
`define MASK_BLEED_READBACK 8'h29
`define MASK_SIGMA_DELTA 8'h35
`define MASK_VCO_LEVEL_D 8'h7f

// Field positions
`define LOSS_LOCK_BIT 0
`define LOCK_COUNT_LSB 1
`define LOCK_COUNT_MSB 2
`define BLEED_POLARITY_BIT 5
`define SPARE_SEL_BIT 3
`define READ_SEL_BIT 0
`define MOD_DISABLE_BIT 0
`define RESET_MASK_BIT 2
`define AUX_MOD_BIT 4
`define HALF_LSB_BIT 5
`define LEVEL_DISABLE_BIT 0
`define TEMP_CAL_BIT 1
`define NOM_THRESH_LSB 2
`define NOM_THRESH_MSB 4
`define LOW_THRESH_BIT 5
`define RECT_BIAS_BIT 6

// Lock detector: base count of 1024 phase detector cycles, doubled per code step
`define LOCK_CNT_W 14
`define LOCK_BASE_COUNT 14'h0400
`define LOCK_CNT_ZERO 14'h0000
`define LOCK_CNT_ONE 14'h0001

// Arbitrary version identification, not tied to any real part
`define VERSION_ID 8'h5a

`endif

// >>> hdl/lock_detector.v
`timescale 1ns/100ps
`default_nettype none
`include "pll_ctrl_defines.vh"

module lock_detector (
	input wire ref_clk,
	input wire rst,
	input wire [1:0] lock_count_select,
	input wire loss_of_lock_enable,
	input wire pfd_strobe,
	input wire pfd_in_window,
	input wire ref_present,
	output reg lock_detect
);
	reg [`LOCK_CNT_W-1:0] count_reg;
	wire [`LOCK_CNT_W-1:0] target;

	// 1024, 2048, 4096 or 8192 cycles for codes 0..3
	assign target = `LOCK_BASE_COUNT << lock_count_select;

	// Counts consecutive in-window cycles; one slip starts the count over
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count_reg <= `LOCK_CNT_ZERO;
			lock_detect <= 1'b0;
		end else if (loss_of_lock_enable && lock_detect && !ref_present) begin
			// Reference gone: no phase detector edges would ever clear lock otherwise
			count_reg <= `LOCK_CNT_ZERO;
			lock_detect <= 1'b0;
		end else if (pfd_strobe) begin
			if (!pfd_in_window) begin
				count_reg <= `LOCK_CNT_ZERO;
				lock_detect <= 1'b0;
			end else if (count_reg + `LOCK_CNT_ONE >= target) begin
				// Saturate so a long lock never wraps
				count_reg <= target;
				lock_detect <= 1'b1;
			end else begin
				count_reg <= count_reg + `LOCK_CNT_ONE;
			end
		end
	end
endmodule // lock_detector

`default_nettype wire

// >>> verif/pll_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pll_regs_checker (
	input wire ref_clk,
	input wire rst,
	input wire reg_wr,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire pfd_strobe,
	input wire pfd_in_window,
	input wire lock_detect,
	input wire bleed_polarity,
	input wire half_lsb_effective,
	input wire aux_modulator_enable,
	input wire modulator_disable_integer,
	input wire sdm_reset,
	input wire level_control_enable,
	input wire temp_calibration_voltage_enable,
	input wire [2:0] core_d_nominal_threshold
);
	// One domain, so clock and reset are stated once
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Write decodes shared by the field checks
	wire w2a = reg_wr && reg_addr == 8'h2a;
	wire w2b = reg_wr && reg_addr == 8'h2b;
	wire w2c = reg_wr && reg_addr == 8'h2c;
	a_lock_cause: assert property ($rose(lock_detect) |-> $past(pfd_strobe && pfd_in_window))
		else $error("lock rose without strobe");
	a_half_gate: assert property (half_lsb_effective |-> !aux_modulator_enable)
		else $error("half lsb with aux on");
	a_bleed_field: assert property (w2a |=> bleed_polarity == $past(reg_wdata[5]))
		else $error("bleed polarity wrong");
	a_mod_disable: assert property (w2b |=> modulator_disable_integer == $past(reg_wdata[0]))
		else $error("modulator control wrong");
	a_alc_enable: assert property (w2c |=> level_control_enable != $past(reg_wdata[0]))
		else $error("level control wrong");
	a_temp_cal: assert property (w2c |=> temp_calibration_voltage_enable == $past(reg_wdata[1]))
		else $error("temp cal wrong");
	a_nom_thresh: assert property (w2c |=> core_d_nominal_threshold == $past(reg_wdata[4:2]))
		else $error("threshold wrong");
	a_sdm_cause: assert property (sdm_reset |-> $past(reg_wr && reg_addr == 8'h10))
		else $error("stray modulator reset");
	a_reserved_zero: assert property (reg_addr == 8'h28 |=> reg_rdata[7:3] == 5'h00)
		else $error("reserved bits set");
endmodule // pll_regs_checker
bind pll_lock_sdm_alc_control_regs pll_regs_checker chk_u (.ref_clk, .rst, .reg_wr, .reg_addr,
	.reg_wdata, .reg_rdata, .pfd_strobe, .pfd_in_window, .lock_detect, .bleed_polarity,
	.half_lsb_effective, .aux_modulator_enable, .modulator_disable_integer, .sdm_reset,
	.level_control_enable, .temp_calibration_voltage_enable, .core_d_nominal_threshold);
`default_nettype wire

// >>> verif/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input wire ref_clk,
	input wire [7:0] reg_rdata,
	output logic reg_wr = 1'b0,
	output logic [7:0] reg_addr = 8'h00,
	output logic [7:0] reg_wdata = 8'h00
);
	// Released data is inverted so a stale value never looks valid
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge ref_clk);
		{reg_wr, reg_wdata} <= {1'b0, ~d};
	endtask
	// Read data is registered, so it is taken one edge after the address
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		@(posedge ref_clk);
		#1 d = reg_rdata;
	endtask
	// Recommended start: loss of lock on, integer mode, aux off, 5 V core
	task setup;
		wr(8'h28, 8'h01);
		wr(8'h2b, 8'h01);
		wr(8'h2c, 8'h44);
	endtask
endmodule // host_model
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "pll_ctrl_defines.vh"
module tb;
	logic ref_clk = 0, rst = 1, pfd_strobe = 0, pfd_in_window = 0, ref_present = 1;
	logic [7:0] d, bias = 8'ha5;
	logic [7:0] ad[5] = '{8'h28, 8'h2a, 8'h2b, 8'h2c, 8'h29};
	logic [7:0] rv[5] = '{8'h03, 8'h00, 8'h01, 8'h44, 8'h00};
	logic [7:0] mv[5] = '{8'h07, 8'h29, 8'h35, 8'h7f, 8'h00};
	wire reg_wr, lock, bp, hl, aux, md, sdm, lce, tc, rb, lt, ss;
	wire [7:0] reg_addr, reg_wdata, reg_rdata, rbd;
	wire [2:0] nt;
	int err_count = 0, checks_done = 0;
	host_model host_u (.ref_clk, .reg_rdata, .reg_wr, .reg_addr, .reg_wdata);
	pll_lock_sdm_alc_control_regs dut_u (.ref_clk, .rst, .reg_wr, .reg_addr, .reg_wdata,
		.reg_rdata, .pfd_strobe, .pfd_in_window, .ref_present, .vco_band_bias_data(bias),
		.lock_detect(lock), .readback_data(rbd), .bleed_polarity(bp), .spare_select(ss),
		.half_lsb_effective(hl), .aux_modulator_enable(aux), .modulator_disable_integer(md),
		.sdm_reset(sdm), .level_control_enable(lce), .temp_calibration_voltage_enable(tc),
		.core_d_rectifier_bias_select(rb), .core_d_low_threshold_select(lt),
		.core_d_nominal_threshold(nt));
	initial forever #2 ref_clk = ~ref_clk;
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Strobe is held for n edges in a row, then dropped; the gap before the next call must not break the run count
	task pulses(input int n, input logic w);
		@(posedge ref_clk);
		{pfd_strobe, pfd_in_window} <= {1'b1, w};
		repeat (n) @(posedge ref_clk);
		pfd_strobe <= 1'b0;
		#1;
	endtask
	// Watchdog against a hung sequence
	initial begin
		repeat (60000) @(posedge ref_clk);
		err_count++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (ad[i]) begin host_u.rd(ad[i], d); chk(d, rv[i]); end
		foreach (ad[i]) begin host_u.wr(ad[i], 8'hff); host_u.rd(ad[i], d); chk(d, mv[i]); end
		chk({lce, tc, rb, lt, nt}, 8'h3f);
		chk({bp, hl, aux, md}, 8'h0b);
		chk(ss, 1'b1);
		chk(rbd, `VERSION_ID);
		host_u.wr(8'h2a, 8'h00);
		@(posedge ref_clk);
		#1 chk(rbd, 8'ha5);
		host_u.wr(8'h2c, 8'h00);
		host_u.wr(8'h2b, 8'h20);
		#1 chk({lce, tc, rb, lt, nt}, 8'h40);
		chk({hl, aux, md}, 8'h04);
		host_u.wr(8'h10, 8'h00);
		#1 chk(sdm, 1'b1);
		host_u.wr(8'h2b, 8'h24);
		host_u.wr(8'h10, 8'h00);
		#1 chk(sdm, 1'b0);
		$display("register tests done");
		host_u.setup();
		for (int c = 0; c < 4; c++) begin
			host_u.wr(8'h28, {5'h00, c[1:0], 1'b1});
			pulses((1024 << c) - 1, 1'b1);
			chk(lock, 1'b0);
			pulses(1, 1'b1);
			chk(lock, 1'b1);
			pulses(1, 1'b0);
		end
		host_u.wr(8'h28, 8'h00);
		pulses(1024, 1'b1);
		ref_present <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1 chk(lock, 1'b1);
		host_u.wr(8'h28, 8'h01);
		repeat (2) @(posedge ref_clk);
		#1 chk(lock, 1'b0);
		$display("lock tests done");
		give_verdict();
	end
endmodule // tb
`default_nettype wire
